// File: rtl/tha_pkg.sv
// Constants, register indices and carrier types of the temperature histogram alarm engine.
// Assumes temperatures in signed 1/32 degC steps and sampling intervals in seconds.
package tha_pkg;
  localparam int NUM_BINS = 16;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL       = 8'h0a;
  localparam logic [7:0] IDX_BIN_ENABLE    = 8'h10;
  localparam logic [7:0] IDX_VALUE_MASK    = 8'h11;
  localparam logic [7:0] IDX_STAMP_MASK    = 8'h12;
  localparam logic [7:0] IDX_UPPER_BASE    = 8'h13;
  localparam logic [7:0] IDX_INTERVAL_BASE = 8'h23;
  localparam logic [7:0] IDX_THRESH_BASE   = 8'h33;
  localparam logic [7:0] IDX_ENERGY_L      = 8'h43;
  localparam logic [7:0] IDX_ENERGY_H      = 8'h44;
  localparam logic [7:0] IDX_KIN_LIMIT     = 8'h45;
  localparam logic [7:0] IDX_REF_TEMP      = 8'h46;
  localparam logic [7:0] IDX_Q10_L         = 8'h47;
  localparam logic [7:0] IDX_Q10_H         = 8'h48;
  localparam logic [7:0] IDX_REF_TIME      = 8'h49;
  localparam logic [7:0] IDX_SHELF_LIMIT   = 8'h4a;
  localparam logic [7:0] IDX_STATUS        = 8'h51;
  localparam logic [7:0] IDX_KIN_RESULT    = 8'h52;
  localparam logic [7:0] IDX_SHELF_L       = 8'h53;
  localparam logic [7:0] IDX_SHELF_H       = 8'h54;
  localparam logic [7:0] IDX_BIN_ALARM     = 8'h55;
  localparam logic [7:0] IDX_COUNT_BASE    = 8'h56;
  localparam logic [7:0] IDX_LAST_SAMPLE   = 8'h66;
  localparam logic [7:0] IDX_SAMPLE_NUM    = 8'h67;
  localparam logic [7:0] IDX_GROUP_SIZE    = 8'h10;
  // Reset values
  localparam logic [15:0] CONTROL_RST    = 16'h0010;
  localparam logic [15:0] BIN_ENABLE_RST = 16'h0001;
  localparam logic [15:0] VALUE_MASK_RST = 16'hffff;
  localparam logic [15:0] STAMP_MASK_RST = 16'h0000;
  localparam logic [15:0] UPPER0_RST     = 16'h08c0;
  localparam logic [15:0] INTERVAL0_RST  = 16'h0258;
  localparam logic [15:0] THRESH_RST     = 16'hffff;
  localparam logic [15:0] ALARM_OFF      = 16'hffff;
  localparam logic [15:0] COUNT_MAX      = 16'hffff;
  // Field positions
  localparam int CTRL_KIN_BIT   = 0;
  localparam int CTRL_SHELF_BIT = 1;
  localparam int STAT_BIN_BIT   = 0;
  localparam int STAT_KIN_BIT   = 1;
  localparam int STAT_SHELF_BIT = 2;
  // Temperature scale: 1/32 degC
  localparam logic signed [15:0] TEMP_MIN = 16'shfd80;
  localparam logic signed [15:0] TEMP_MAX = 16'sh08c0;
  localparam logic [31:0] KELVIN_OFFSET   = 32'h0000_2225;
  localparam logic [63:0] TEMP_SCALE      = 64'h20;
  localparam logic [63:0] Q10_STEP        = 64'h140;
  // Fixed-point arithmetic constants
  localparam logic [63:0] GAS_R_MILLI   = 64'h207a;
  localparam logic [63:0] MILLI         = 64'h3e8;
  localparam logic [63:0] LOG2E_Q8      = 64'h171;
  localparam logic [31:0] LN2_Q8        = 32'hb1;
  localparam logic [63:0] Q8_ONE        = 64'h100;
  localparam logic [9:0]  EXP_ONE_Q9    = 10'h200;
  localparam logic [7:0]  EXP_FRAC_BITS = 8'h09;
  localparam logic [7:0]  KIN_BIAS      = 8'h38;
  localparam logic [7:0]  SHELF_BIAS    = 8'h20;
  localparam logic [15:0] KIN_BIAS_Q8   = 16'h3800;
  localparam logic [15:0] Q16_LOG_Q8    = 16'h1000;
  localparam logic [63:0] SEC_PER_HOUR  = 64'he10;
  localparam logic [4:0]  BIN_NONE      = 5'h10;

  typedef struct packed {
    logic               valid;
    logic signed [15:0] temp;
  } tha_sample_s;
endpackage

// File: rtl/tha_engine.sv
// Temperature histogram and alarm engine: bins, counters, interval switch, log strobes,
// mean kinetic temperature and remaining shelf life, with an APB register slave.
// Assumes the sampler sits on MCLK_IN and presents one-cycle sample pulses.
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ns
module tha_engine
  import tha_pkg::*;
(
  input  wire logic        MCLK_IN,
  input  wire logic        RESET_N_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic        LOGGING_ACTIVE_IN,
  input  wire tha_sample_s SAMPLE_IN,
  output logic             LOG_VALUE_WE_OUT,
  output logic             LOG_STAMP_WE_OUT,
  output logic      [15:0] LOG_VALUE_OUT,
  output logic      [15:0] SAMPLE_INTERVAL_OUT,
  output logic             BIN_ALARM_OUT,
  output logic             KINETIC_ALARM_OUT,
  output logic             SHELF_ALARM_OUT
);

  // 2^(bias - z), z in Q8; fraction approximated linearly, so error stays under 7 percent
  function automatic logic [79:0] exp2_q(input logic [15:0] z, input logic [7:0] bias);
    logic [9:0] mant;
    mant = EXP_ONE_Q9 - {2'b00, z[7:0]};
    return (80'(mant) << bias) >> (z[15:8] + EXP_FRAC_BITS);
  endfunction

  // log2 in Q8 of a non-zero integer, fraction taken linearly from the bits below the top one
  function automatic logic [15:0] log2_q8(input logic [79:0] v);
    logic [7:0]  p;
    logic [79:0] w;
    p = 8'h00;
    for (int i = 0; i < 80; i++) begin
      if (v[i]) begin
        p = 8'(i);
      end
    end
    w = v << (8'd79 - p);
    return {p, w[78:71]};
  endfunction

  function automatic logic in_group(input logic [7:0] idx, input logic [7:0] base);
    return (idx >= base) && (idx < base + IDX_GROUP_SIZE);
  endfunction

  // Lowest bin whose upper limit covers the sample; bin 15 ends at the tag maximum
  function automatic logic [4:0] find_bin(input logic signed [15:0] t,
                                          input logic [NUM_BINS-1:0][15:0] up);
    logic [4:0]         r;
    logic               found;
    logic signed [15:0] hi;
    r = BIN_NONE;
    found = 1'b0;
    if (t > TEMP_MIN && t <= TEMP_MAX) begin
      for (int i = 0; i < NUM_BINS; i++) begin
        hi = (i == NUM_BINS - 1) ? TEMP_MAX : signed'(up[i]);
        if (!found && t <= hi) begin
          r = 5'(i);
          found = 1'b1;
        end
      end
    end
    return r;
  endfunction

  logic [15:0]                 control;
  logic [15:0]                 bin_enable;
  logic [15:0]                 bin_value_store_mask;
  logic [15:0]                 bin_stamp_store_mask;
  logic [NUM_BINS-1:0][15:0]   bin_upper_limit;
  logic [NUM_BINS-1:0][15:0]   bin_sample_interval;
  logic [NUM_BINS-1:0][15:0]   bin_threshold;
  logic [NUM_BINS-1:0][15:0]   bin_counter;
  logic [15:0]                 bin_alarm;
  logic [31:0]                 kinetic_energy;
  logic [15:0]                 kinetic_limit;
  logic [15:0]                 kinetic_result;
  logic [15:0]                 shelf_ref_temp;
  logic [31:0]                 shelf_q10;
  logic [15:0]                 shelf_ref_time;
  logic [15:0]                 shelf_limit;
  logic [31:0]                 shelf_remaining;
  logic [63:0]                 shelf_consumed;
  logic [79:0]                 kin_sum;
  logic [31:0]                 kin_count;
  logic                        kin_calc;
  logic [15:0]                 last_sample;
  logic [15:0]                 sample_num;
  logic [3:0]                  cur_bin;
  logic                        cur_valid;

  logic [7:0]  reg_idx;
  logic        addr_ok;
  logic        apb_access;
  logic        apb_write;
  logic [15:0] rd_data;
  logic        rd_hit;
  logic        wr_hit;

  assign reg_idx    = PADDR_IN[9:2];
  assign addr_ok    = (PADDR_IN[11:10] == 2'b00) && (PADDR_IN[1:0] == 2'b00);
  assign apb_access = PSEL_IN && PENABLE_IN;
  // Writes land at the edge where the master sees PREADY, so a retried access is harmless
  assign apb_write  = apb_access && PREADY_OUT && PWRITE_IN && !PSLVERR_OUT;

  always_comb begin
    rd_hit  = addr_ok;
    rd_data = 16'h0000;
    if (in_group(reg_idx, IDX_UPPER_BASE)) begin
      rd_data = bin_upper_limit[4'(reg_idx - IDX_UPPER_BASE)];
    end else if (in_group(reg_idx, IDX_INTERVAL_BASE)) begin
      rd_data = bin_sample_interval[4'(reg_idx - IDX_INTERVAL_BASE)];
    end else if (in_group(reg_idx, IDX_THRESH_BASE)) begin
      rd_data = bin_threshold[4'(reg_idx - IDX_THRESH_BASE)];
    end else if (in_group(reg_idx, IDX_COUNT_BASE)) begin
      rd_data = bin_counter[4'(reg_idx - IDX_COUNT_BASE)];
    end else begin
      unique case (reg_idx)
        IDX_CONTROL:     rd_data = control;
        IDX_BIN_ENABLE:  rd_data = bin_enable;
        IDX_VALUE_MASK:  rd_data = bin_value_store_mask;
        IDX_STAMP_MASK:  rd_data = bin_stamp_store_mask;
        IDX_ENERGY_L:    rd_data = kinetic_energy[15:0];
        IDX_ENERGY_H:    rd_data = kinetic_energy[31:16];
        IDX_KIN_LIMIT:   rd_data = kinetic_limit;
        IDX_REF_TEMP:    rd_data = shelf_ref_temp;
        IDX_Q10_L:       rd_data = shelf_q10[15:0];
        IDX_Q10_H:       rd_data = shelf_q10[31:16];
        IDX_REF_TIME:    rd_data = shelf_ref_time;
        IDX_SHELF_LIMIT: rd_data = shelf_limit;
        IDX_STATUS: begin
          rd_data[STAT_BIN_BIT]   = BIN_ALARM_OUT;
          rd_data[STAT_KIN_BIT]   = KINETIC_ALARM_OUT;
          rd_data[STAT_SHELF_BIT] = SHELF_ALARM_OUT;
        end
        IDX_KIN_RESULT:  rd_data = kinetic_result;
        IDX_SHELF_L:     rd_data = shelf_remaining[15:0];
        IDX_SHELF_H:     rd_data = shelf_remaining[31:16];
        IDX_BIN_ALARM:   rd_data = bin_alarm;
        IDX_LAST_SAMPLE: rd_data = last_sample;
        IDX_SAMPLE_NUM:  rd_data = sample_num;
        default:         rd_hit  = 1'b0;
      endcase
    end
  end

  // One wait state: PREADY rises in the second access cycle
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      PREADY_OUT  <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT  <= 32'h0000_0000;
    end else begin
      PREADY_OUT  <= apb_access && !PREADY_OUT;
      PSLVERR_OUT <= apb_access && !PREADY_OUT && !rd_hit;
      if (apb_access && !PREADY_OUT) begin
        PRDATA_OUT <= {16'h0000, rd_data};
      end
    end
  end

  assign wr_hit = apb_write;

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      control              <= CONTROL_RST;
      bin_enable           <= BIN_ENABLE_RST;
      bin_value_store_mask <= VALUE_MASK_RST;
      bin_stamp_store_mask <= STAMP_MASK_RST;
      kinetic_energy       <= 32'h0000_0000;
      kinetic_limit        <= 16'h0000;
      shelf_ref_temp       <= 16'h0000;
      shelf_q10            <= 32'h0000_0000;
      shelf_ref_time       <= 16'h0000;
      shelf_limit          <= 16'h0000;
      for (int i = 0; i < NUM_BINS; i++) begin
        bin_upper_limit[i]     <= (i == 0) ? UPPER0_RST : 16'h0000;
        bin_sample_interval[i] <= (i == 0) ? INTERVAL0_RST : 16'h0000;
        bin_threshold[i]       <= THRESH_RST;
      end
    end else if (wr_hit) begin
      if (in_group(reg_idx, IDX_UPPER_BASE)) begin
        bin_upper_limit[4'(reg_idx - IDX_UPPER_BASE)] <= PWDATA_IN[15:0];
      end else if (in_group(reg_idx, IDX_INTERVAL_BASE)) begin
        bin_sample_interval[4'(reg_idx - IDX_INTERVAL_BASE)] <= PWDATA_IN[15:0];
      end else if (in_group(reg_idx, IDX_THRESH_BASE)) begin
        bin_threshold[4'(reg_idx - IDX_THRESH_BASE)] <= PWDATA_IN[15:0];
      end else begin
        // Read-only registers fall through silently
        unique case (reg_idx)
          IDX_CONTROL:     control              <= PWDATA_IN[15:0];
          IDX_BIN_ENABLE:  bin_enable           <= PWDATA_IN[15:0];
          IDX_VALUE_MASK:  bin_value_store_mask <= PWDATA_IN[15:0];
          IDX_STAMP_MASK:  bin_stamp_store_mask <= PWDATA_IN[15:0];
          IDX_ENERGY_L:    kinetic_energy[15:0] <= PWDATA_IN[15:0];
          IDX_ENERGY_H:    kinetic_energy[31:16] <= PWDATA_IN[15:0];
          IDX_KIN_LIMIT:   kinetic_limit        <= PWDATA_IN[15:0];
          IDX_REF_TEMP:    shelf_ref_temp       <= PWDATA_IN[15:0];
          IDX_Q10_L:       shelf_q10[15:0]      <= PWDATA_IN[15:0];
          IDX_Q10_H:       shelf_q10[31:16]     <= PWDATA_IN[15:0];
          IDX_REF_TIME:    shelf_ref_time       <= PWDATA_IN[15:0];
          IDX_SHELF_LIMIT: shelf_limit          <= PWDATA_IN[15:0];
          default: ;
        endcase
      end
    end
  end

  // Sample classification
  logic        take;
  logic [4:0]  hit_bin;
  logic [3:0]  hit_idx;
  logic        in_bin;
  logic        bin_on;
  logic        bin_change;
  logic [15:0] use_interval;

  assign take         = SAMPLE_IN.valid && LOGGING_ACTIVE_IN;
  assign hit_bin      = find_bin(SAMPLE_IN.temp, bin_upper_limit);
  assign hit_idx      = hit_bin[3:0];
  assign in_bin       = take && !hit_bin[4];
  assign bin_on       = in_bin && bin_enable[hit_idx];
  assign bin_change   = in_bin && (!cur_valid || hit_idx != cur_bin);
  assign use_interval = bin_change ? bin_sample_interval[hit_idx] : SAMPLE_INTERVAL_OUT;

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      bin_counter <= '0;
      last_sample <= 16'h0000;
      sample_num  <= 16'h0000;
    end else if (take) begin
      last_sample <= SAMPLE_IN.temp;
      if (sample_num != COUNT_MAX) begin
        sample_num <= sample_num + 16'h0001;
      end
      // Counters saturate rather than wrap so an alarm can never clear itself
      if (bin_on && bin_counter[hit_idx] != COUNT_MAX) begin
        bin_counter[hit_idx] <= bin_counter[hit_idx] + 16'h0001;
      end
    end
  end

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      cur_bin             <= 4'h0;
      cur_valid           <= 1'b0;
      SAMPLE_INTERVAL_OUT <= INTERVAL0_RST;
    end else if (bin_change) begin
      cur_bin             <= hit_idx;
      cur_valid           <= 1'b1;
      SAMPLE_INTERVAL_OUT <= bin_sample_interval[hit_idx];
    end
  end

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      LOG_VALUE_WE_OUT <= 1'b0;
      LOG_STAMP_WE_OUT <= 1'b0;
      LOG_VALUE_OUT    <= 16'h0000;
    end else begin
      LOG_VALUE_WE_OUT <= bin_on && bin_value_store_mask[hit_idx];
      LOG_STAMP_WE_OUT <= bin_on && bin_stamp_store_mask[hit_idx];
      if (take) begin
        LOG_VALUE_OUT <= SAMPLE_IN.temp;
      end
    end
  end

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      bin_alarm     <= 16'h0000;
      BIN_ALARM_OUT <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_BINS; i++) begin
        bin_alarm[i] <= (bin_threshold[i] != ALARM_OFF) &&
                        (bin_counter[i] >= bin_threshold[i]);
      end
      BIN_ALARM_OUT <= |bin_alarm;
    end
  end

  // Mean kinetic temperature: accumulate exp(-a/T) scaled by 2^56, evaluate a cycle later
  logic [31:0] act_ratio;
  logic [31:0] temp_k32;
  logic [63:0] kin_z;
  logic [79:0] kin_term;
  logic [79:0] kin_avg;
  logic [15:0] kin_log;
  logic [31:0] kin_den;
  logic [63:0] kin_k32;

  assign act_ratio = 32'((64'(kinetic_energy) * MILLI) / GAS_R_MILLI);
  assign temp_k32  = 32'(signed'(SAMPLE_IN.temp)) + KELVIN_OFFSET;
  assign kin_z     = (64'(act_ratio) * TEMP_SCALE * LOG2E_Q8) / 64'(temp_k32);
  assign kin_term  = (kin_z >= 64'(KIN_BIAS_Q8)) ? 80'h0 : exp2_q(16'(kin_z), KIN_BIAS);
  assign kin_avg   = (kin_count == 32'h0) ? 80'h0 : kin_sum / 80'(kin_count);
  assign kin_log   = (kin_avg == 80'h0) ? 16'h0000 : log2_q8(kin_avg);
  assign kin_den   = 32'((32'(KIN_BIAS_Q8 - kin_log) * LN2_Q8) >> 8) | 32'h1;
  assign kin_k32   = (64'(act_ratio) * TEMP_SCALE * Q8_ONE) / 64'(kin_den);

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      kin_sum           <= 80'h0;
      kin_count         <= 32'h0;
      kin_calc          <= 1'b0;
      kinetic_result    <= 16'h0000;
      KINETIC_ALARM_OUT <= 1'b0;
    end else begin
      kin_calc <= take && control[CTRL_KIN_BIT];
      if (take && control[CTRL_KIN_BIT]) begin
        kin_sum   <= kin_sum + kin_term;
        kin_count <= kin_count + 32'h1;
      end
      if (kin_calc) begin
        kinetic_result    <= 16'(kin_k32 - 64'(KELVIN_OFFSET));
        KINETIC_ALARM_OUT <= signed'(16'(kin_k32 - 64'(KELVIN_OFFSET)))
                             > signed'(kinetic_limit);
      end
    end
  end

  // Shelf life: Q10 is Q16.16, factor 2^(log2(Q10)*dT/10) kept in Q16, hours in Q16
  logic signed [63:0] shelf_log;
  logic signed [63:0] shelf_z;
  logic signed [63:0] shelf_zc;
  logic signed [63:0] shelf_cap;
  logic [79:0]        shelf_factor;
  logic [63:0]        shelf_next;
  logic [31:0]        shelf_used;

  assign shelf_log = 64'(signed'({1'b0, log2_q8(80'(shelf_q10))})) - 64'(Q16_LOG_Q8);
  assign shelf_z   = (shelf_log * 64'(signed'(SAMPLE_IN.temp - signed'(shelf_ref_temp))))
                     / signed'(Q10_STEP);
  // Signed bound, or a sample cooler than the reference would clamp to the hot end
  assign shelf_cap = signed'(64'(Q16_LOG_Q8));
  assign shelf_zc  = (shelf_z > shelf_cap) ? shelf_cap :
                     (shelf_z < -shelf_cap) ? -shelf_cap : shelf_z;
  assign shelf_factor = exp2_q(16'(64'(Q16_LOG_Q8) - shelf_zc), SHELF_BIAS);
  assign shelf_next   = shelf_consumed +
                        (shelf_factor[63:0] * 64'(use_interval)) / SEC_PER_HOUR;
  assign shelf_used   = shelf_next[47:16];

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      shelf_consumed  <= 64'h0;
      shelf_remaining <= 32'h0000_0000;
      SHELF_ALARM_OUT <= 1'b0;
    end else if (take && control[CTRL_SHELF_BIT]) begin
      shelf_consumed <= shelf_next;
      // Remaining life floors at zero instead of wrapping to a huge figure
      if (shelf_used >= 32'(shelf_ref_time)) begin
        shelf_remaining <= 32'h0000_0000;
        SHELF_ALARM_OUT <= 32'h0 < 32'(shelf_limit);
      end else begin
        shelf_remaining <= 32'(shelf_ref_time) - shelf_used;
        SHELF_ALARM_OUT <= (32'(shelf_ref_time) - shelf_used) < 32'(shelf_limit);
      end
    end
  end

endmodule

// File: tb/tha_engine_monitor.sv
// Port checker of the histogram alarm engine.
// Assumes it is bound to tha_engine and sees only that module's ports.
`timescale 1ns/1ns
module tha_engine_monitor
  import tha_pkg::*;
(
  input wire logic        MCLK_IN,
  input wire logic        RESET_N_IN,
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PREADY_OUT,
  input wire logic        PSLVERR_OUT,
  input wire logic        LOGGING_ACTIVE_IN,
  input wire tha_sample_s SAMPLE_IN,
  input wire logic        LOG_VALUE_WE_OUT,
  input wire logic        LOG_STAMP_WE_OUT,
  input wire logic [15:0] SAMPLE_INTERVAL_OUT
);
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  wire take = SAMPLE_IN.valid && LOGGING_ACTIVE_IN;
  wire oor  = (SAMPLE_IN.temp <= TEMP_MIN) || (SAMPLE_IN.temp > TEMP_MAX);
  property p_ready_wait; PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT; endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("ready late");
  property p_ready_pulse; PREADY_OUT |=> !PREADY_OUT; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
  property p_err_ready; PSLVERR_OUT |-> PREADY_OUT && PSEL_IN; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_value_cause; LOG_VALUE_WE_OUT |-> $past(take); endproperty
  a_value_cause: assert property (p_value_cause) else $error("stray value strobe");
  property p_stamp_cause; LOG_STAMP_WE_OUT |-> $past(take); endproperty
  a_stamp_cause: assert property (p_stamp_cause) else $error("stray stamp strobe");
  property p_idle_hold; !take |=> $stable(SAMPLE_INTERVAL_OUT); endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("interval moved");
  property p_range;
    take && oor |=> !LOG_VALUE_WE_OUT && !LOG_STAMP_WE_OUT && $stable(SAMPLE_INTERVAL_OUT);
  endproperty
  a_range: assert property (p_range) else $error("out of range sample used");
  property p_inactive;
    SAMPLE_IN.valid && !LOGGING_ACTIVE_IN |=> !LOG_VALUE_WE_OUT && !LOG_STAMP_WE_OUT;
  endproperty
  a_inactive: assert property (p_inactive) else $error("sample used while idle");
  c_value: cover property (LOG_VALUE_WE_OUT);
  c_stamp: cover property (LOG_STAMP_WE_OUT);
  c_err: cover property (PSLVERR_OUT);
endmodule

// File: tb/tha_sampler_model.sv
// Temperature sampler stand-in: one-cycle sample pulse for each bench request.
// Assumes requests far enough apart for the engine's two-cycle spacing.
`timescale 1ns/1ns
module tha_sampler_model
  import tha_pkg::*;
(
  input  wire logic               clk_in,
  input  wire logic               rst_n_in,
  input  wire logic               req_in,
  input  wire logic signed [15:0] temp_in,
  output tha_sample_s             sample_out
);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sample_out <= '0;
    end else if (req_in) begin
      sample_out <= '{valid: 1'b1, temp: temp_in};
    end else begin
      // Value is not held outside a pulse, so a late read shows up
      sample_out <= '{valid: 1'b0, temp: ~sample_out.temp};
    end
  end
endmodule

// File: tb/tb_top.sv
// Self-checking bench of the histogram alarm engine: APB master plus sampler model.
// Assumes the one-wait-state APB slave and one-cycle strobes of the engine.
`timescale 1ns/1ns
module tb_top
  import tha_pkg::*;
;
  logic               clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, act = 0, req = 0;
  logic        [11:0] paddr = '0;
  logic        [31:0] pwdata = '0, prdata;
  logic signed [15:0] tmp = '0, r;
  logic               pready, perr, vwe, swe, balm, kalm, salm, pend = 0;
  logic        [15:0] ivl, lval;
  logic        [33:0] snotes[$];
  logic        [33:0] sn;
  tha_sample_s        smp;
  int                 bad_count = 0, n_checks = 0;
  logic        [33:0] notes[$];
  logic        [33:0] nt;
  localparam logic [7:0] RI[9] = '{IDX_CONTROL, IDX_BIN_ENABLE, IDX_VALUE_MASK, IDX_STAMP_MASK,
    IDX_UPPER_BASE, IDX_INTERVAL_BASE, IDX_THRESH_BASE, IDX_THRESH_BASE + 8'h0f, IDX_COUNT_BASE};
  localparam logic [15:0] RV[9] = '{CONTROL_RST, BIN_ENABLE_RST, VALUE_MASK_RST, STAMP_MASK_RST,
    UPPER0_RST, INTERVAL0_RST, THRESH_RST, THRESH_RST, 16'h0000};
  localparam logic [7:0] WI[7] = '{IDX_UPPER_BASE, IDX_UPPER_BASE + 8'h01, IDX_BIN_ENABLE,
    IDX_VALUE_MASK, IDX_STAMP_MASK, IDX_INTERVAL_BASE + 8'h01, IDX_THRESH_BASE + 8'h01};
  // Bin 15 stamp bit set though bin 15 stays disabled, while bin 1 values are dropped
  localparam logic [15:0] WV[7] = '{16'h0000, 16'h0140, 16'h0003, 16'h0001, 16'h8002,
    16'h0010, 16'h0002};
  localparam logic [7:0] QI[6] = '{IDX_COUNT_BASE + 8'h01, IDX_COUNT_BASE,
    IDX_COUNT_BASE + 8'h0f, IDX_BIN_ALARM, IDX_KIN_RESULT, IDX_SHELF_L};
  localparam logic [15:0] QV[6] = '{16'h0002, 16'h0001, 16'h0000, 16'h0002, 16'h0000, 16'h0000};
  // Both sums on: ratio 10000 K, limit -10 degC, Q10 of 2, 10 h reference, 5 h limit
  localparam logic [7:0] KI[7] = '{IDX_CONTROL, IDX_ENERGY_L, IDX_ENERGY_H, IDX_KIN_LIMIT,
    IDX_Q10_H, IDX_REF_TIME, IDX_SHELF_LIMIT};
  localparam logic [15:0] KV[7] = '{16'h0003, 16'h44c4, 16'h0001, 16'hfec0, 16'h0002,
    16'h000a, 16'h0005};

  tha_sampler_model i_smp (.clk_in(clk), .rst_n_in(rst_n), .req_in(req), .temp_in(tmp),
    .sample_out(smp));
  tha_engine i_dut (.MCLK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(perr), .LOGGING_ACTIVE_IN(act), .SAMPLE_IN(smp),
    .LOG_VALUE_WE_OUT(vwe), .LOG_STAMP_WE_OUT(swe), .LOG_VALUE_OUT(lval),
    .SAMPLE_INTERVAL_OUT(ivl), .BIN_ALARM_OUT(balm), .KINETIC_ALARM_OUT(kalm),
    .SHELF_ALARM_OUT(salm));

  always #5 clk = ~clk;

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [15:0] d,
                     input logic err, input logic [15:0] exp);
    notes.push_back({~wr, err, wr ? 32'h0 : {16'h0, exp}});
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {16'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic sample(input logic a, input logic signed [15:0] t, input logic v,
                        input logic s, input logic [15:0] iv);
    snotes.push_back({v, s, iv, t});
    @(posedge clk);
    act <= a;
    req <= 1'b1;
    tmp <= t;
    @(posedge clk);
    req <= 1'b0;
    @(posedge clk);
  endtask

  always @(posedge clk) begin
    if (psel && pen && pready === 1'b1) begin
      nt = notes.pop_front();
      check({perr, nt[33] ? prdata : 32'h0}, nt[32:0]);
    end
  end

  // Results of a sample stand from the edge after the engine takes it
  always @(posedge clk) begin
    if (pend) begin
      sn = snotes.pop_front();
      check({31'h0, vwe, swe}, {31'h0, sn[33:32]});
      check({17'h0, ivl}, {17'h0, sn[31:16]});
      if (sn[33]) begin
        check({17'h0, lval}, {17'h0, sn[15:0]});
      end
    end
    pend <= smp.valid;
  end

  initial begin
    void'($urandom(32'h6247));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, RI[i], 16'h0, 1'b0, RV[i]);
    end
    apb(1'b0, 8'h4b, 16'h0, 1'b1, 16'h0);
    $display("test reset_values done");
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, WI[i], WV[i], 1'b0, 16'h0);
    end
    r = 16'(1 + $urandom % 320);
    sample(1'b1, r, 1'b0, 1'b1, 16'h0010);
    sample(1'b1, 16'sh0000, 1'b1, 1'b0, INTERVAL0_RST);
    sample(1'b1, TEMP_MIN, 1'b0, 1'b0, INTERVAL0_RST);
    sample(1'b1, 16'(1 + $urandom % 320), 1'b0, 1'b1, 16'h0010);
    sample(1'b1, 16'sh03e8, 1'b0, 1'b0, 16'h0000);
    sample(1'b0, r, 1'b0, 1'b0, 16'h0000);
    $display("test histogram done");
    check({32'h0, balm}, 33'h1);
    check({31'h0, kalm, salm}, 33'h0);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, QI[i], 16'h0, 1'b0, QV[i]);
    end
    apb(1'b1, IDX_COUNT_BASE, 16'h1234, 1'b0, 16'h0);
    apb(1'b0, IDX_COUNT_BASE, 16'h0, 1'b0, 16'h0001);
    $display("test alarms done");
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, KI[i], KV[i], 1'b0, 16'h0);
    end
    sample(1'b1, -16'sh0020, 1'b1, 1'b0, INTERVAL0_RST);
    repeat (3) @(posedge clk);
    check({31'h0, kalm, salm}, 33'h2);
    apb(1'b1, IDX_SHELF_LIMIT, 16'h000c, 1'b0, 16'h0);
    sample(1'b1, -16'sh0020, 1'b1, 1'b0, INTERVAL0_RST);
    repeat (3) @(posedge clk);
    apb(1'b0, IDX_STATUS, 16'h0, 1'b0, 16'h0007);
    $display("test kinetic_shelf done");
    repeat (2) @(posedge clk);
    test_done();
  end

  initial begin
    #100000;
    bad_count++;
    test_done();
  end
endmodule

bind tha_engine tha_engine_monitor i_mon (.MCLK_IN(MCLK_IN), .RESET_N_IN(RESET_N_IN),
  .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PREADY_OUT(PREADY_OUT),
  .PSLVERR_OUT(PSLVERR_OUT), .LOGGING_ACTIVE_IN(LOGGING_ACTIVE_IN), .SAMPLE_IN(SAMPLE_IN),
  .LOG_VALUE_WE_OUT(LOG_VALUE_WE_OUT), .LOG_STAMP_WE_OUT(LOG_STAMP_WE_OUT),
  .SAMPLE_INTERVAL_OUT(SAMPLE_INTERVAL_OUT));
